// ### csp_cmp_chan.sv
// One compare channel: match detect, output latch, flag and trigger pulses.
`timescale 1ns/1ps
module csp_cmp_chan
	import csp_pkg::*;
(
	input  wire logic        clk_i,     // System clock
	input  wire logic        rst_i,     // Synchronous reset
	input  wire logic [15:0] count_i,   // Timer1 count
	input  wire logic [15:0] value_i,   // Compare value
	input  wire logic [3:0]  mode_i,    // Current mode field
	input  wire logic        ctl_wr_i,  // Control register write strobe
	input  wire logic [3:0]  ctl_mode_i,// Mode being written
	input  wire logic        run_i,     // Low while asleep
	output logic             match_o,   // Equality level
	output logic             out_o,     // Compare output latch
	output logic             drive_o,   // Unit owns its pin
	output logic             flag_o,    // One-cycle match flag pulse
	output logic             trig_o     // One-cycle special event pulse
);
	logic match_q_r;
	logic evt;

	assign match_o = (count_i == value_i);
	// Only the rising of equality counts, so a stalled timer flags once
	assign evt = match_o && !match_q_r && run_i;
	// Software interrupt and trigger modes leave the pin alone
	assign drive_o = (mode_i == MODE_TOGGLE) || (mode_i == MODE_SET)
		|| (mode_i == MODE_CLR);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_q_r <= 1'b0;
		end else begin
			match_q_r <= match_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_o <= 1'b0;
		end else if (ctl_wr_i) begin
			if (ctl_mode_i == MODE_OFF || ctl_mode_i == MODE_SET) begin
				out_o <= 1'b0;
			end else if (ctl_mode_i == MODE_CLR) begin
				out_o <= 1'b1;
			end
		end else if (evt) begin
			unique case (mode_i)
				MODE_TOGGLE: out_o <= !out_o;
				MODE_SET:    out_o <= 1'b1;
				MODE_CLR:    out_o <= 1'b0;
				default:     out_o <= out_o;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_o <= 1'b0;
			trig_o <= 1'b0;
		end else begin
			flag_o <= evt && is_cmp_mode(mode_i);
			trig_o <= evt && (mode_i == MODE_SEVT);
		end
	end
endmodule // csp_cmp_chan

// ### csp_compare_props.sv
// Checker for bus, steering, pin and event outputs of the compare unit.
`timescale 1ns/1ps
module csp_compare_props
	import csp_pkg::*;
(
	input wire logic        clk_i,          // Clock
	input wire logic        rst_i,          // Reset
	input wire logic        wb_cyc_i,       // Cycle
	input wire logic        wb_stb_i,       // Strobe
	input wire logic        wb_we_i,        // Write
	input wire logic [7:0]  wb_adr_i,       // Address
	input wire logic [31:0] wb_dat_o,       // Read data
	input wire logic        wb_ack_o,       // Ack
	input wire logic        sleep_i,        // Sleep
	input wire logic        ss_pa5_i,       // Select pa5
	input wire logic        ss_pa0_i,       // Select pa0
	input wire logic        ss_sel_o,       // Steered select
	input wire logic        unit1_oe_o,     // Unit 1 enable
	input wire logic        unit2_pc1_oe_o, // Unit 2 pc1 enable
	input wire logic        unit2_pb3_oe_o, // Unit 2 pb3 enable
	input wire logic        adc_go_o,       // ADC start
	input wire logic        trig_o,         // Special event
	input wire logic        irq_o           // Interrupt
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ss_hi;
		(ss_pa5_i && ss_pa0_i)[*6];
	endsequence
	sequence s_ss_lo;
		(!ss_pa5_i && !ss_pa0_i)[*6];
	endsequence

	a_ack_answer: assert property (s_req |=> wb_ack_o) else $error("no ack");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i &&
		(wb_adr_i > 8'h30 || wb_adr_i[1:0] != 2'b00) |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_steer_upper_zero: assert property (wb_ack_o && !wb_we_i &&
		wb_adr_i == ADR_STEER |-> wb_dat_o[31:2] == 30'h0) else $error("steer upper bits");
	a_ss_follow_hi: assert property (s_ss_hi |-> ss_sel_o) else $error("select high");
	a_ss_follow_lo: assert property (s_ss_lo |-> !ss_sel_o) else $error("select low");
	a_unit2_one_pin: assert property (!(unit2_pc1_oe_o && unit2_pb3_oe_o))
		else $error("unit 2 on two pins");
	a_adc_with_trig: assert property (adc_go_o |-> trig_o) else $error("adc alone");
	a_trig_pulse: assert property (trig_o |=> !trig_o) else $error("trigger too long");
	a_sleep_quiet: assert property (sleep_i[*4] |-> !trig_o && !adc_go_o)
		else $error("event in sleep");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !trig_o
		&& !adc_go_o && !irq_o && !unit1_oe_o && ss_sel_o) else $error("reset values");
endmodule // csp_compare_props

bind csp_compare_top csp_compare_props u_props (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_i(sleep_i), .ss_pa5_i(ss_pa5_i),
	.ss_pa0_i(ss_pa0_i), .ss_sel_o(ss_sel_o), .unit1_oe_o(unit1_oe_o),
	.unit2_pc1_oe_o(unit2_pc1_oe_o), .unit2_pb3_oe_o(unit2_pb3_oe_o),
	.adc_go_o(adc_go_o), .trig_o(trig_o), .irq_o(irq_o));

// ### csp_compare_top.sv
// Compare unit pair with timer1, pin steering and a Wishbone register file.
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module csp_compare_top
	import csp_pkg::*;
(
	input  wire logic        clk_i,        // System clock, 50 MHz
	input  wire logic        rst_i,        // Synchronous reset, active high
	input  wire logic        wb_cyc_i,     // Wishbone cycle
	input  wire logic        wb_stb_i,     // Wishbone strobe
	input  wire logic        wb_we_i,      // Wishbone write enable
	input  wire logic [7:0]  wb_adr_i,     // Byte address
	input  wire logic [3:0]  wb_sel_i,     // Byte lanes
	input  wire logic [31:0] wb_dat_i,     // Write data
	output logic [31:0]      wb_dat_o,     // Read data
	output logic             wb_ack_o,     // Acknowledge
	input  wire logic        t1_ck_pin_i,  // External timer1 clock pin
	input  wire logic        t1_gate_pin_i,// Timer1 gate pin
	input  wire logic        sleep_i,      // Sleep request from core logic
	input  wire logic        ss_pa5_i,     // Slave select on port A pin 5
	input  wire logic        ss_pa0_i,     // Slave select on port A pin 0
	output logic             ss_sel_o,     // Steered slave select level
	output logic             unit1_o,      // Unit 1 pin value
	output logic             unit1_oe_o,   // Unit 1 pin enable
	output logic             unit2_pc1_o,  // Unit 2 on port C pin 1
	output logic             unit2_pc1_oe_o,// Enable for port C pin 1
	output logic             unit2_pb3_o,  // Unit 2 on port B pin 3
	output logic             unit2_pb3_oe_o,// Enable for port B pin 3
	output logic             adc_go_o,     // One-cycle ADC start pulse
	output logic             trig_o,       // One-cycle special event pulse
	output logic             irq_o         // Level interrupt
);
	logic [1:0]  steer_r;
	logic [5:0]  ctl1_r;
	logic [5:0]  ctl2_r;
	logic [15:0] val1_r;
	logic [15:0] val2_r;
	logic [3:0]  t1ctl_r;
	logic [15:0] t1_r;
	logic [2:0]  irq_stat_r;
	logic [2:0]  irq_mask_r;
	logic [1:0]  pin_dir_r;
	logic [1:0]  presc_r;
	logic        ack_r;
	logic [31:0] rdat_nxt;
	logic        wr_en;
	logic        lane0;

	// Pin synchronisers
	logic ck_s1_r, ck_s2_r, ck_s3_r;
	logic gt_s1_r, gt_s2_r;
	logic s5_s1_r, s5_s2_r;
	logic s0_s1_r, s0_s2_r;

	logic run;
	logic tick;
	logic t1_count_en;
	logic sevt_hold;
	logic m1, m2, o1, o2, d1, d2, f1, f2, tr1, tr2;
	logic wr_ctl1, wr_ctl2;

	function automatic logic adr_hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	// Bus side
	assign lane0 = wb_sel_i[0];
	// Writes land on the edge where the master sees ack high
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && lane0;
	assign wr_ctl1 = wr_en && adr_hit(wb_adr_i, ADR_CTL1);
	assign wr_ctl2 = wr_en && adr_hit(wb_adr_i, ADR_CTL2);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
			wb_dat_o <= rdat_nxt;
		end
	end
	assign wb_ack_o = ack_r;

	always_comb begin
		rdat_nxt = 32'h0000_0000;
		unique case (wb_adr_i)
			ADR_STEER:    rdat_nxt[1:0] = steer_r;
			ADR_CTL1:     rdat_nxt[5:0] = ctl1_r;
			ADR_CTL2:     rdat_nxt[5:0] = ctl2_r;
			ADR_VAL1_LO:  rdat_nxt[7:0] = val1_r[7:0];
			ADR_VAL1_HI:  rdat_nxt[7:0] = val1_r[15:8];
			ADR_VAL2_LO:  rdat_nxt[7:0] = val2_r[7:0];
			ADR_VAL2_HI:  rdat_nxt[7:0] = val2_r[15:8];
			ADR_T1CTL:    rdat_nxt[3:0] = t1ctl_r;
			ADR_T1_LO:    rdat_nxt[7:0] = t1_r[7:0];
			ADR_T1_HI:    rdat_nxt[7:0] = t1_r[15:8];
			ADR_IRQ_STAT: rdat_nxt[2:0] = irq_stat_r;
			ADR_IRQ_MASK: rdat_nxt[2:0] = irq_mask_r;
			ADR_PIN_DIR:  rdat_nxt[1:0] = pin_dir_r;
			default:      rdat_nxt = 32'h0000_0000;
		endcase
	end

	// Configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			steer_r <= STEER_RST;
		end else if (wr_en && adr_hit(wb_adr_i, ADR_STEER)) begin
			steer_r <= wb_dat_i[1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl1_r <= CTL_RST;
			ctl2_r <= CTL_RST;
		end else begin
			if (wr_ctl1) begin
				ctl1_r <= wb_dat_i[5:0];
			end
			if (wr_ctl2) begin
				ctl2_r <= wb_dat_i[5:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			val1_r <= VAL_RST;
			val2_r <= VAL_RST;
		end else if (wr_en) begin
			if (adr_hit(wb_adr_i, ADR_VAL1_LO)) begin
				val1_r[7:0] <= wb_dat_i[7:0];
			end
			if (adr_hit(wb_adr_i, ADR_VAL1_HI)) begin
				val1_r[15:8] <= wb_dat_i[7:0];
			end
			if (adr_hit(wb_adr_i, ADR_VAL2_LO)) begin
				val2_r[7:0] <= wb_dat_i[7:0];
			end
			if (adr_hit(wb_adr_i, ADR_VAL2_HI)) begin
				val2_r[15:8] <= wb_dat_i[7:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			t1ctl_r <= T1CTL_RST;
			irq_mask_r <= IRQ_RST;
			pin_dir_r <= PIN_DIR_RST;
		end else if (wr_en) begin
			if (adr_hit(wb_adr_i, ADR_T1CTL)) begin
				t1ctl_r <= wb_dat_i[3:0];
			end
			if (adr_hit(wb_adr_i, ADR_IRQ_MASK)) begin
				irq_mask_r <= wb_dat_i[2:0];
			end
			if (adr_hit(wb_adr_i, ADR_PIN_DIR)) begin
				pin_dir_r <= wb_dat_i[1:0];
			end
		end
	end

	// Pin inputs pass two flops; the third stage only feeds edge detect
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ck_s1_r <= 1'b0;
			ck_s2_r <= 1'b0;
			ck_s3_r <= 1'b0;
			gt_s1_r <= 1'b0;
			gt_s2_r <= 1'b0;
			s5_s1_r <= 1'b1;
			s5_s2_r <= 1'b1;
			s0_s1_r <= 1'b1;
			s0_s2_r <= 1'b1;
		end else begin
			ck_s1_r <= t1_ck_pin_i;
			ck_s2_r <= ck_s1_r;
			ck_s3_r <= ck_s2_r;
			gt_s1_r <= t1_gate_pin_i;
			gt_s2_r <= gt_s1_r;
			s5_s1_r <= ss_pa5_i;
			s5_s2_r <= s5_s1_r;
			s0_s1_r <= ss_pa0_i;
			s0_s2_r <= s0_s1_r;
		end
	end

	// Timer1: internal quarter-rate tick or synchronised external edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			presc_r <= 2'h0;
		end else begin
			presc_r <= presc_r + 2'h1;
		end
	end

	// The system clock halts in sleep, so nothing counts or matches then
	assign run = !sleep_i;
	assign tick = run && (t1ctl_r[T1_EXTCK] ? (ck_s2_r && !ck_s3_r)
		: (presc_r == PRESC_LAST));
	assign t1_count_en = t1ctl_r[T1_ON]
		&& (!t1ctl_r[T1_GATE] || gt_s2_r);
	// Re-checked at the reset edge, so a moved compare value cancels it
	assign sevt_hold = (m1 && ctl1_r[3:0] == MODE_SEVT)
		|| (m2 && ctl2_r[3:0] == MODE_SEVT);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			t1_r <= 16'h0000;
		end else if (wr_en && adr_hit(wb_adr_i, ADR_T1_LO)) begin
			t1_r[7:0] <= wb_dat_i[7:0];
		end else if (wr_en && adr_hit(wb_adr_i, ADR_T1_HI)) begin
			t1_r[15:8] <= wb_dat_i[7:0];
		end else if (tick && t1_count_en) begin
			if (sevt_hold) begin
				t1_r <= 16'h0000;
			end else begin
				t1_r <= t1_r + 16'h0001;
			end
		end
	end

	// Compare channels
	csp_cmp_chan u_chan1 (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.count_i    (t1_r),
		.value_i    (val1_r),
		.mode_i     (ctl1_r[3:0]),
		.ctl_wr_i   (wr_ctl1),
		.ctl_mode_i (wb_dat_i[3:0]),
		.run_i      (run),
		.match_o    (m1),
		.out_o      (o1),
		.drive_o    (d1),
		.flag_o     (f1),
		.trig_o     (tr1)
	);

	csp_cmp_chan u_chan2 (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.count_i    (t1_r),
		.value_i    (val2_r),
		.mode_i     (ctl2_r[3:0]),
		.ctl_wr_i   (wr_ctl2),
		.ctl_mode_i (wb_dat_i[3:0]),
		.run_i      (run),
		.match_o    (m2),
		.out_o      (o2),
		.drive_o    (d2),
		.flag_o     (f2),
		.trig_o     (tr2)
	);

	// Sticky status; a new event beats a same-cycle clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_r <= IRQ_RST;
		end else begin
			if (wr_en && adr_hit(wb_adr_i, ADR_IRQ_STAT)) begin
				irq_stat_r <= irq_stat_r & ~wb_dat_i[2:0];
			end
			if (f1) begin
				irq_stat_r[IRQ_CMP1] <= 1'b1;
			end
			if (f2) begin
				irq_stat_r[IRQ_CMP2] <= 1'b1;
			end
			// Trigger resets clear to zero without passing the wrap
			if (tick && t1_count_en && !sevt_hold && t1_r == 16'hffff) begin
				irq_stat_r[IRQ_OVF] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat_r & irq_mask_r);
		end
	end

	// Trigger and ADC start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trig_o <= 1'b0;
			adc_go_o <= 1'b0;
		end else begin
			trig_o <= tr1 || tr2;
			adc_go_o <= tr2 && t1ctl_r[T1_ADC_EN];
		end
	end

	// Pin steering; direction bit low means output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ss_sel_o <= 1'b1;
			unit1_o <= 1'b0;
			unit1_oe_o <= 1'b0;
			unit2_pc1_o <= 1'b0;
			unit2_pc1_oe_o <= 1'b0;
			unit2_pb3_o <= 1'b0;
			unit2_pb3_oe_o <= 1'b0;
		end else begin
			ss_sel_o <= steer_r[STEER_SS] ? s0_s2_r : s5_s2_r;
			unit1_o <= o1;
			unit1_oe_o <= d1 && !pin_dir_r[0];
			unit2_pc1_o <= o2 && !steer_r[STEER_UNIT2];
			unit2_pc1_oe_o <= d2 && !pin_dir_r[1] && !steer_r[STEER_UNIT2];
			unit2_pb3_o <= o2 && steer_r[STEER_UNIT2];
			unit2_pb3_oe_o <= d2 && !pin_dir_r[1] && steer_r[STEER_UNIT2];
		end
	end
endmodule // csp_compare_top

// ### csp_far_model.sv
// Far-side model: timer1 clock and gate pins and the slave-select lines.
`timescale 1ns/1ps
module csp_far_model (
	input  wire logic       clk_i,       // Clock
	input  wire logic       ck_run_i,    // Run the external timer1 clock
	input  wire logic       gate_open_i, // Gate level wanted
	input  wire logic [1:0] ss_lvl_i,    // Levels of pa0, pa5
	output logic            t1_ck_o,     // External timer1 clock
	output logic            t1_gate_o,   // Timer1 gate
	output logic            ss_pa5_o,    // Select on pa5
	output logic            ss_pa0_o     // Select on pa0
);
	logic [1:0] ck_div;

	// External clock at a quarter of the system rate; it rests low when not run
	always @(posedge clk_i) begin
		ck_div <= ck_run_i ? ck_div + 2'h1 : 2'h0;
		t1_ck_o <= ck_run_i && ck_div[1];
		t1_gate_o <= gate_open_i;
		{ss_pa0_o, ss_pa5_o} <= ss_lvl_i;
	end
	initial begin
		ck_div = 2'h0;
		t1_ck_o = 1'b0;
		t1_gate_o = 1'b0;
		{ss_pa0_o, ss_pa5_o} = 2'h3;
	end
endmodule // csp_far_model

// ### csp_pkg.sv
// Constants for the compare unit with pin steering.
// Functional notes
// - Compare full 16-bit value against timer1 count continuously; equality is a match.
// - On match act per 4-bit mode: toggle, set, clear, trigger or interrupt only.
// - Every compare mode sets the unit's interrupt flag on a match.
// - Mode 1010 sets the flag and leaves the pin uncontrolled.
// - Mode 1011 resets timer1; unit 2 with ADC enabled starts conversion.
// - Trigger fires at match; timer cleared at next timer1 clock edge.
// - Trigger-caused timer1 reset never sets the overflow flag.
// - If match vanishes before the reset edge, the timer reset is skipped.
// - Writing zero to control forces compare output latch low.
// - Compare actions need not happen during sleep.
// - Steering bit 0 routes unit 2 to port C pin 1 or port B pin 3.
// - Steering bit 1 takes slave select from port A pin 5 or pin 0.
// - Steering bits 7..2 read zero; both steering bits reset to zero.
// - Timer1 off when on bit 0; gated by input when gate enable set.
package csp_pkg;
	localparam logic [7:0] ADR_STEER    = 8'h00;
	localparam logic [7:0] ADR_CTL1     = 8'h04;
	localparam logic [7:0] ADR_CTL2     = 8'h08;
	localparam logic [7:0] ADR_VAL1_LO  = 8'h0c;
	localparam logic [7:0] ADR_VAL1_HI  = 8'h10;
	localparam logic [7:0] ADR_VAL2_LO  = 8'h14;
	localparam logic [7:0] ADR_VAL2_HI  = 8'h18;
	localparam logic [7:0] ADR_T1CTL    = 8'h1c;
	localparam logic [7:0] ADR_T1_LO    = 8'h20;
	localparam logic [7:0] ADR_T1_HI    = 8'h24;
	localparam logic [7:0] ADR_IRQ_STAT = 8'h28;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h2c;
	localparam logic [7:0] ADR_PIN_DIR  = 8'h30;

	localparam int STEER_UNIT2 = 0;
	localparam int STEER_SS    = 1;
	localparam logic [1:0] STEER_RST = 2'h0;

	localparam int T1_ON     = 0;
	localparam int T1_GATE   = 1;
	localparam int T1_EXTCK  = 2;
	localparam int T1_ADC_EN = 3;
	localparam logic [3:0] T1CTL_RST = 4'h0;

	localparam int IRQ_CMP1 = 0;
	localparam int IRQ_CMP2 = 1;
	localparam int IRQ_OVF  = 2;
	localparam logic [2:0] IRQ_RST = 3'h0;

	localparam logic [1:0] PIN_DIR_RST = 2'h3;
	localparam logic [5:0] CTL_RST     = 6'h00;
	localparam logic [15:0] VAL_RST    = 16'h0000;

	localparam logic [1:0] PRESC_LAST = 2'h3;

	localparam logic [3:0] MODE_OFF    = 4'h0;
	localparam logic [3:0] MODE_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_SET    = 4'h8;
	localparam logic [3:0] MODE_CLR    = 4'h9;
	localparam logic [3:0] MODE_SWI    = 4'ha;
	localparam logic [3:0] MODE_SEVT   = 4'hb;

	function automatic logic is_cmp_mode(input logic [3:0] m);
		return (m == MODE_TOGGLE) || (m[3:2] == 2'b10);
	endfunction
endpackage

// ### tb_top.sv
// Self-checking bench for the compare unit with pin steering.
`timescale 1ns/1ps
module tb_top;
	import csp_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic        sleep = 1'b0, gate = 1'b0, ack, ck, gpin, pa5, pa0, ss;
	logic        u1, u1oe, pc1, pc1oe, pb3, pb3oe, adc, trig, irq;
	logic [1:0]  ss_lvl = 2'h3;
	logic        ck_run = 1'b0;
	int          failures = 0, checked = 0, cycles = 0;

	always #10 clk = ~clk;

	csp_compare_top dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .t1_ck_pin_i(ck), .t1_gate_pin_i(gpin), .sleep_i(sleep),
		.ss_pa5_i(pa5), .ss_pa0_i(pa0), .ss_sel_o(ss), .unit1_o(u1), .unit1_oe_o(u1oe),
		.unit2_pc1_o(pc1), .unit2_pc1_oe_o(pc1oe), .unit2_pb3_o(pb3),
		.unit2_pb3_oe_o(pb3oe), .adc_go_o(adc), .trig_o(trig), .irq_o(irq));
	csp_far_model far (.clk_i(clk), .ck_run_i(ck_run), .gate_open_i(gate),
		.ss_lvl_i(ss_lvl), .t1_ck_o(ck),
		.t1_gate_o(gpin), .ss_pa5_o(pa5), .ss_pa0_o(pa0));

	task automatic test_done;
		$display("checked %0d, failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("wrong value at %0t: run too long", $time);
			test_done;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h", $time, m, got);
		end
	endtask

	// Request held until ack is sampled high; one idle cycle follows
	// Only the run's own cycle limit ends a wait for ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk(ack, 1'b1, "bus ack");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
		bus(1'b0, a, 32'h0);
		chk(q, e, m);
	endtask

	// Waits for trigger (0), unit 2 pb3 pin (1) or unit 1 pin (2)
	task automatic wt(input int k);
		int n;
		n = 0;
		while (n < 400 && !(k == 0 ? trig === 1'b1 : k == 1 ? pb3 === 1'b1 : u1 === 1'b1))
		begin
			@(posedge clk);
			n++;
		end
		chk(n < 400, 1'b1, "event wait");
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(ADR_STEER, 32'h0, "steer reset");
		rd(ADR_CTL2, 32'h0, "ctl2 reset");
		rd(ADR_PIN_DIR, 32'h3, "dir reset");
		rd(8'h34, 32'h0, "unmapped");
		wr(ADR_STEER, 32'hff);
		rd(ADR_STEER, 32'h3, "steer bits");
		ss_lvl <= 2'h0;
		repeat (8) @(posedge clk);
		ss_lvl <= 2'h2;
		repeat (8) @(posedge clk);
		chk(ss, 1'b1, "select pa0");
		wr(ADR_STEER, 32'h1);
		repeat (8) @(posedge clk);
		chk(ss, 1'b0, "select pa5");
		$display("test registers and steering done");
		wr(ADR_PIN_DIR, 32'h0);
		wr(ADR_VAL2_LO, 32'h14);
		wr(ADR_CTL2, {28'h0, MODE_SET});
		wr(ADR_T1CTL, 32'h1);
		wt(1);
		chk({pb3oe, pc1oe, pc1}, 3'b100, "unit2 pin");
		rd(ADR_IRQ_STAT, 32'h2, "unit2 flag");
		chk(irq, 1'b0, "masked irq");
		wr(ADR_CTL2, 32'h0);
		repeat (3) @(posedge clk);
		chk(pb3, 1'b0, "latch low");
		$display("test set mode done");
		wr(ADR_T1CTL, 32'h0);
		wr(ADR_T1_LO, 32'h0);
		wr(ADR_VAL1_LO, 32'h8);
		wr(ADR_CTL1, {28'h0, MODE_TOGGLE});
		wr(ADR_IRQ_STAT, 32'h7);
		wr(ADR_IRQ_MASK, 32'h1);
		wr(ADR_T1CTL, 32'h1);
		wt(2);
		repeat (2) @(posedge clk);
		chk({irq, u1oe}, 2'b11, "irq up");
		wr(ADR_IRQ_STAT, 32'h1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0, "irq cleared");
		$display("test toggle and interrupt done");
		wr(ADR_T1CTL, 32'h0);
		wr(ADR_T1_LO, 32'h0);
		wr(ADR_CTL1, 32'h0);
		wr(ADR_VAL2_LO, 32'h5);
		wr(ADR_CTL2, {28'h0, MODE_SEVT});
		wr(ADR_IRQ_STAT, 32'h7);
		wr(ADR_T1CTL, 32'h9);
		wt(0);
		chk({adc, pb3oe}, 2'b10, "adc start, pin free");
		repeat (6) @(posedge clk);
		bus(1'b0, ADR_T1_LO, 32'h0);
		chk(q < 32'h4, 1'b1, "timer cleared");
		rd(ADR_IRQ_STAT, 32'h2, "no overflow");
		// Trigger at the top count: a missed reset would wrap and flag overflow
		wr(ADR_T1CTL, 32'h0);
		wr(ADR_VAL2_HI, 32'hff);
		wr(ADR_VAL2_LO, 32'hff);
		wr(ADR_T1_HI, 32'hff);
		wr(ADR_T1_LO, 32'hf8);
		wr(ADR_IRQ_STAT, 32'h7);
		wr(ADR_T1CTL, 32'h1);
		wt(0);
		repeat (8) @(posedge clk);
		rd(ADR_IRQ_STAT, 32'h2, "wrap by trigger");
		// Match removed while the timer is stopped: no reset may follow
		wr(ADR_T1CTL, 32'h0);
		wr(ADR_T1_LO, 32'h0);
		wr(ADR_VAL2_HI, 32'h0);
		wr(ADR_VAL2_LO, 32'h5);
		wr(ADR_T1_LO, 32'h5);
		wt(0);
		wr(ADR_VAL2_LO, 32'h20);
		wr(ADR_T1CTL, 32'h1);
		repeat (8) @(posedge clk);
		bus(1'b0, ADR_T1_LO, 32'h0);
		chk(q > 32'h5, 1'b1, "reset skipped");
		$display("test special event done");
		wr(ADR_CTL2, 32'h0);
		wr(ADR_T1CTL, 32'h0);
		wr(ADR_T1_LO, 32'h0);
		wr(ADR_T1CTL, 32'h3);
		repeat (20) @(posedge clk);
		rd(ADR_T1_LO, 32'h0, "gate closed");
		gate <= 1'b1;
		repeat (20) @(posedge clk);
		bus(1'b0, ADR_T1_LO, 32'h0);
		chk(q > 32'h2, 1'b1, "gate open");
		sleep <= 1'b1;
		wr(ADR_T1_LO, 32'h0);
		repeat (20) @(posedge clk);
		rd(ADR_T1_LO, 32'h0, "sleep holds");
		sleep <= 1'b0;
		$display("test gate and sleep done");
		wr(ADR_T1CTL, 32'h0);
		wr(ADR_T1_LO, 32'h0);
		wr(ADR_T1CTL, 32'h5);
		repeat (20) @(posedge clk);
		rd(ADR_T1_LO, 32'h0, "no external edges");
		ck_run <= 1'b1;
		repeat (20) @(posedge clk);
		bus(1'b0, ADR_T1_LO, 32'h0);
		chk(q > 32'h2, 1'b1, "external clock");
		ck_run <= 1'b0;
		$display("test external clock done");
		test_done;
	end
endmodule // tb_top
